//--- rtl/udc_ctrl_regs.sv
// Functional notes
// [RULE1] Power state reported as one-hot 7-bit code, seven states, others unused.
// [RULE2] Off code shown while powered off, detached or disabled.
// [RULE3] Reserved bits read zero; software writes them as zero.
// [RULE4] 32-bit writable descriptor table base pointer.
// [RULE5] Software keeps the two low pointer bits zero.
// [RULE6] Software loads pad trim values before enabling the controller.
// [RULE7] Pad trim holds edge trim 14:12, NMOS 10:6, PMOS 4:0.
// [RULE8] Power-management reply: 0 none, 1 ACK, 2 NYET, 3 reserved.
// [RULE9] All-NAK bit forces NAK on every transaction, else real status; the code answers LPM and ignored endpoint-0 tokens without it.
// [RULE10] All-NAK acts directly, with no synchroniser in its path.
// [RULE11] Setup-only bit ignores endpoint-0 traffic except SETUP.
// [RULE12] Setup-only bit clears itself when a SETUP arrives.
// [RULE13] Speed select: 0 full speed, 1 low speed, others reserved.
// [RULE14] Writing one to remote wake starts upstream resume; zero ignored.
// [RULE15] Remote wake clears on bus reset or when resume is sent.
// [RULE16] Detach resets to one; clearing it attaches the device.
// [RULE17] Address zero until address valid set, then the programmed address.
// [RULE18] Bus reset clears address valid.
// [RULE19] Bus reset clears the function address.
// [RULE20] Line state reads 0 SE0, 1 FS-J/LS-K, 2 FS-K/LS-J.
// [RULE21] Speed status reads 0 low speed, 1 full speed.
// [RULE22] Power, line and speed status tracked continuously, no handshake.
`timescale 1ns/1ps
`default_nettype none

module udc_ctrl_regs #(
	parameter int RESUME_CYCLES = udc_pkg::RESUME_CYCLES
) (
	input  wire logic          i_clk_sys,
	input  wire logic          i_srst,
	// Register port
	input  wire logic [7:0]    i_addr,
	input  wire logic [31:0]   i_wr_data,
	input  wire logic          i_wr_stb,
	input  wire logic          i_rd_stb,
	output logic [31:0]        o_rd_data,
	// Link events
	input  wire logic          i_ctrl_enable,
	input  wire logic          i_bus_reset,
	input  wire logic          i_suspend_det,
	input  wire logic          i_lpm_sleep,
	input  wire logic          i_resume_det,
	input  wire logic          i_resume_end,
	input  wire logic [1:0]    i_line_state,
	// Token in, handshake out
	input  wire logic          i_tok_valid,
	input  wire logic          i_tok_ep0,
	input  wire logic          i_tok_setup,
	input  wire logic          i_tok_lpm,
	input  wire udc_pkg::udc_hs_t i_ep_status,
	output logic               o_hs_valid,
	output udc_pkg::udc_hs_t   o_hs_code,
	// Controls to the rest of the controller
	output logic               o_pullup_en,
	output logic               o_speed_low,
	output logic               o_drive_resume,
	output logic [6:0]         o_dev_addr,
	output logic [31:0]        o_desc_base,
	output logic [2:0]         o_edge_trim,
	output logic [4:0]         o_nmos_trim,
	output logic [4:0]         o_pmos_trim,
	output logic [6:0]         o_link_power_state
);
	import udc_pkg::*;

	localparam int CW = $clog2(RESUME_CYCLES + 1);

	typedef struct packed {
		logic [15:0] device_control;
		logic [7:0]  function_address;
		logic [31:0] descriptor_base;
		logic [15:0] pad_trim;
		udc_lps_t    lps;
		logic [CW-1:0] resume_cnt;
		logic [6:0]  power_code;
		logic [1:0]  line_state;
		logic [1:0]  speed_status;
		logic [6:0]  dev_addr;
		logic        pullup_en;
		logic        speed_low;
		logic        drive_resume;
		logic        hs_valid;
		udc_hs_t     hs_code;
		logic [31:0] rd_data;
	} udc_state_t;

	udc_state_t st_reg;
	udc_state_t st_next;

	logic          detach;
	logic          wake_req;
	logic          setup_only;
	logic          all_nak;
	logic [1:0]    speed_sel;
	logic [1:0]    lpm_sel;
	logic          addr_valid;
	logic [15:0]   wr_ctrl;
	logic [7:0]    link_status;

	always_comb begin
		detach     = st_reg.device_control[POS_DETACH];
		wake_req   = st_reg.device_control[POS_REMOTE_WAKE];
		setup_only = st_reg.device_control[POS_SETUP_ONLY];
		all_nak    = st_reg.device_control[POS_ALL_NAK];
		speed_sel  = st_reg.device_control[POS_SPEED_LO +: 2];
		lpm_sel    = st_reg.device_control[POS_LPM_LO +: 2];
		addr_valid = st_reg.function_address[POS_ADDR_VALID];
		wr_ctrl    = i_wr_data[15:0] & MASK_DEVICE_CONTROL; // [RULE3]
		link_status = 8'h00;
		link_status[POS_STAT_LINE +: 2]  = st_reg.line_state; // [RULE20]
		link_status[POS_STAT_SPEED +: 2] = st_reg.speed_status; // [RULE21]
	end

	always_comb begin
		st_next = st_reg;
		st_next.hs_valid = 1'b0;
		st_next.rd_data  = 32'h00000000;

		// Hardware clears come first so a same-cycle software write wins
		if (i_tok_valid && i_tok_ep0 && i_tok_setup) begin
			st_next.device_control[POS_SETUP_ONLY] = 1'b0; // [RULE12]
		end
		if (i_bus_reset) begin
			st_next.device_control[POS_REMOTE_WAKE] = 1'b0; // [RULE15]
			st_next.function_address[POS_ADDR_VALID] = 1'b0; // [RULE18]
			st_next.function_address[6:0] = 7'h00; // [RULE19]
		end

		// Link power state machine
		case (st_reg.lps)
			LPS_OFF: begin
				if (i_ctrl_enable && !detach) begin
					st_next.lps = LPS_ON;
				end
			end
			LPS_ON: begin
				if (i_suspend_det) begin
					st_next.lps = LPS_SUSPEND;
				end else if (i_lpm_sleep) begin
					st_next.lps = LPS_SLEEP;
				end
			end
			LPS_SUSPEND, LPS_SLEEP: begin
				if (i_resume_det) begin
					st_next.lps = LPS_DOWNSTREAM_RESUME_STATE;
				end else if (wake_req) begin
					st_next.lps = LPS_UPSTREAM_RESUME_STATE; // [RULE14]
					st_next.resume_cnt = CW'(RESUME_CYCLES - 1);
				end
			end
			LPS_DOWNSTREAM_RESUME_STATE: begin
				if (i_resume_end) begin
					st_next.lps = LPS_ON;
				end
			end
			LPS_UPSTREAM_RESUME_STATE: begin
				if (st_reg.resume_cnt == '0) begin
					st_next.lps = LPS_ON;
					st_next.device_control[POS_REMOTE_WAKE] = 1'b0; // [RULE15]
				end else begin
					st_next.resume_cnt = st_reg.resume_cnt - CW'(1);
				end
			end
			LPS_RESET: begin
				if (!i_bus_reset) begin
					st_next.lps = LPS_ON;
				end
			end
			default: begin
				st_next.lps = LPS_OFF;
			end
		endcase
		// Bus reset outranks every state but off; off outranks everything
		if (i_bus_reset && st_reg.lps != LPS_OFF) begin
			st_next.lps = LPS_RESET;
		end
		if (!i_ctrl_enable || detach) begin
			st_next.lps = LPS_OFF; // [RULE2]
		end

		// Software writes
		if (i_wr_stb) begin
			case (i_addr)
				OFS_DEVICE_CONTROL: begin
					// Remote wake is set-only: a zero keeps what hardware left,
					// a one beats a hardware clear in the same cycle
					st_next.device_control = wr_ctrl |
						(st_next.device_control & (16'h0001 << POS_REMOTE_WAKE)); // [RULE14]
				end
				OFS_FUNCTION_ADDR: begin
					st_next.function_address = i_wr_data[7:0]; // [RULE17]
				end
				OFS_DESCRIPTOR_BASE: begin
					st_next.descriptor_base = i_wr_data; // [RULE4]
				end
				OFS_PAD_TRIM: begin
					st_next.pad_trim = i_wr_data[15:0] & MASK_PAD_TRIM; // [RULE7]
				end
				default: begin
				end
			endcase
		end

		// Software reads, answered one cycle later
		if (i_rd_stb) begin
			case (i_addr)
				OFS_DEVICE_CONTROL: begin
					st_next.rd_data = {16'h0000, st_reg.device_control};
				end
				OFS_FUNCTION_ADDR: begin
					st_next.rd_data = {24'h000000, st_reg.function_address};
				end
				OFS_LINK_STATUS: begin
					st_next.rd_data = {24'h000000, link_status};
				end
				OFS_LINK_POWER: begin
					st_next.rd_data = {25'h0000000, st_reg.power_code}; // [RULE3]
				end
				OFS_DESCRIPTOR_BASE: begin
					st_next.rd_data = st_reg.descriptor_base;
				end
				OFS_PAD_TRIM: begin
					st_next.rd_data = {16'h0000, st_reg.pad_trim};
				end
				default: begin
					st_next.rd_data = 32'h00000000;
				end
			endcase
		end

		// Status tracks the link every cycle
		case (st_reg.lps)
			LPS_OFF:      st_next.power_code = 7'h01; // [RULE1]
			LPS_ON:       st_next.power_code = 7'h02;
			LPS_SUSPEND:  st_next.power_code = 7'h04;
			LPS_SLEEP:    st_next.power_code = 7'h08;
			LPS_DOWNSTREAM_RESUME_STATE: st_next.power_code = 7'h10;
			LPS_UPSTREAM_RESUME_STATE: st_next.power_code = 7'h20;
			LPS_RESET:    st_next.power_code = 7'h40;
			default:      st_next.power_code = RST_POWER_CODE;
		endcase
		st_next.line_state = i_line_state; // [RULE22]
		st_next.speed_status = (speed_sel == SPD_LOW) ? STAT_LOW : STAT_FULL; // [RULE13]
		st_next.speed_low    = (speed_sel == SPD_LOW); // [RULE13]
		st_next.dev_addr = addr_valid ? st_reg.function_address[6:0] : 7'h00; // [RULE17]
		st_next.pullup_en    = !detach; // [RULE16]
		st_next.drive_resume = (st_reg.lps == LPS_UPSTREAM_RESUME_STATE); // [RULE14]

		// Handshake choice; the all-NAK bit is read straight from the register
		if (i_tok_valid) begin
			if (i_tok_lpm) begin
				st_next.hs_valid = 1'b1;
				case (lpm_sel) // [RULE8]
					LPM_ACK:  st_next.hs_code = HS_ACK;
					LPM_NYET: st_next.hs_code = HS_NYET;
					default:  st_next.hs_code = HS_NONE;
				endcase
			end else if (setup_only && i_tok_ep0 && !i_tok_setup) begin
				st_next.hs_valid = 1'b1;
				st_next.hs_code  = HS_NONE; // [RULE11]
			end else begin
				st_next.hs_valid = 1'b1;
				st_next.hs_code  = all_nak ? HS_NAK : i_ep_status; // [RULE9] [RULE10]
			end
		end

		if (i_srst) begin
			st_next.device_control   = RST_DEVICE_CONTROL; // [RULE16]
			st_next.function_address = RST_FUNCTION_ADDR;
			st_next.descriptor_base  = RST_DESCRIPTOR_BASE;
			st_next.pad_trim         = RST_PAD_TRIM;
			st_next.lps              = LPS_OFF;
			st_next.resume_cnt       = '0;
			st_next.power_code       = RST_POWER_CODE;
			st_next.line_state       = RST_LINE_STATE;
			st_next.speed_status     = RST_SPEED_STATUS;
			st_next.dev_addr         = 7'h00;
			st_next.pullup_en        = 1'b0;
			st_next.speed_low        = 1'b0;
			st_next.drive_resume     = 1'b0;
			st_next.hs_valid         = 1'b0;
			st_next.hs_code          = HS_NONE;
			st_next.rd_data          = 32'h00000000;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		st_reg <= st_next;
	end

	assign o_rd_data          = st_reg.rd_data;
	assign o_hs_valid         = st_reg.hs_valid;
	assign o_hs_code          = st_reg.hs_code;
	assign o_pullup_en        = st_reg.pullup_en;
	assign o_speed_low        = st_reg.speed_low;
	assign o_drive_resume     = st_reg.drive_resume;
	assign o_dev_addr         = st_reg.dev_addr;
	assign o_desc_base        = st_reg.descriptor_base; // [RULE4]
	assign o_edge_trim        = st_reg.pad_trim[POS_EDGE_LO +: 3];
	assign o_nmos_trim        = st_reg.pad_trim[POS_NMOS_LO +: 5];
	assign o_pmos_trim        = st_reg.pad_trim[POS_PMOS_LO +: 5];
	assign o_link_power_state = st_reg.power_code;
endmodule : udc_ctrl_regs

`default_nettype wire

//--- rtl/udc_pkg.sv
`default_nettype none
package udc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_DEVICE_CONTROL  = 8'h08;
	localparam logic [7:0] OFS_FUNCTION_ADDR   = 8'h0A;
	localparam logic [7:0] OFS_LINK_STATUS     = 8'h0C;
	localparam logic [7:0] OFS_LINK_POWER      = 8'h0D;
	localparam logic [7:0] OFS_DESCRIPTOR_BASE = 8'h24;
	localparam logic [7:0] OFS_PAD_TRIM        = 8'h28;

	// Reset values
	localparam logic [15:0] RST_DEVICE_CONTROL  = 16'h0001;
	localparam logic [7:0]  RST_FUNCTION_ADDR   = 8'h00;
	localparam logic [31:0] RST_DESCRIPTOR_BASE = 32'h00000000;
	localparam logic [15:0] RST_PAD_TRIM        = 16'h0000;
	localparam logic [6:0]  RST_POWER_CODE      = 7'h01;
	localparam logic [1:0]  RST_LINE_STATE      = 2'h1;
	localparam logic [1:0]  RST_SPEED_STATUS    = 2'h1;

	// Writable bit masks; everything else is reserved and reads zero
	localparam logic [15:0] MASK_DEVICE_CONTROL = 16'h0E1F;
	localparam logic [15:0] MASK_PAD_TRIM       = 16'h77DF;

	// device_control field positions
	localparam int POS_DETACH      = 0;
	localparam int POS_REMOTE_WAKE = 1;
	localparam int POS_SPEED_LO    = 2;
	localparam int POS_SETUP_ONLY  = 4;
	localparam int POS_ALL_NAK     = 9;
	localparam int POS_LPM_LO      = 10;
	// function_address_reg field positions
	localparam int POS_ADDR_VALID  = 7;
	// pad_trim_reg field positions
	localparam int POS_PMOS_LO     = 0;
	localparam int POS_NMOS_LO     = 6;
	localparam int POS_EDGE_LO     = 12;
	// link_status field positions
	localparam int POS_STAT_SPEED  = 2;
	localparam int POS_STAT_LINE   = 6;

	// Selector encodings
	localparam logic [1:0] LPM_NONE   = 2'h0;
	localparam logic [1:0] LPM_ACK    = 2'h1;
	localparam logic [1:0] LPM_NYET   = 2'h2;
	localparam logic [1:0] SPD_FULL   = 2'h0;
	localparam logic [1:0] SPD_LOW    = 2'h1;
	localparam logic [1:0] STAT_LOW   = 2'h0;
	localparam logic [1:0] STAT_FULL  = 2'h1;

	// Upstream resume drive time
	localparam int CLK_MHZ           = 250;
	localparam int RESUME_DRIVE_US   = 2000;
	localparam int RESUME_CYCLES     = RESUME_DRIVE_US * CLK_MHZ;

	// Link power states, Gray along off-on-suspend-sleep-resume
	typedef enum logic [2:0] {
		LPS_OFF      = 3'h0,
		LPS_ON       = 3'h1,
		LPS_SUSPEND  = 3'h3,
		LPS_SLEEP    = 3'h2,
		LPS_DOWNSTREAM_RESUME_STATE = 3'h6,
		LPS_UPSTREAM_RESUME_STATE = 3'h7,
		LPS_RESET    = 3'h5
	} udc_lps_t;

	// Handshake answers
	typedef enum logic [2:0] {
		HS_NONE  = 3'h0,
		HS_ACK   = 3'h1,
		HS_NAK   = 3'h2,
		HS_STALL = 3'h3,
		HS_NYET  = 3'h4
	} udc_hs_t;
endpackage : udc_pkg
`default_nettype wire

//--- bench/udc_ctrl_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module udc_ctrl_regs_chk #(
	parameter int RESUME_CYCLES = 8
) (
	input wire logic        i_clk_sys,
	input wire logic        i_srst,
	input wire logic [7:0]  i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic        i_wr_stb,
	input wire logic        i_ctrl_enable,
	input wire logic        i_bus_reset,
	input wire logic        i_tok_valid,
	input wire logic        o_hs_valid,
	input wire logic        o_pullup_en,
	input wire logic        o_drive_resume,
	input wire logic [6:0]  o_dev_addr,
	input wire logic [6:0]  o_link_power_state
);
	import udc_pkg::*;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	// Writes show two edges later: one to store, one to register the output
	property p_hot; $onehot(o_link_power_state); endproperty
	a_hot: assert property (p_hot) else $error("power code not one-hot");
	property p_off; !i_ctrl_enable |-> ##2 o_link_power_state == 7'h01; endproperty
	a_off: assert property (p_off) else $error("disabled but not off");
	property p_pull;
		i_wr_stb && i_addr == OFS_DEVICE_CONTROL ##1 !i_wr_stb
			|-> ##1 o_pullup_en == !$past(i_wr_data[0], 2);
	endproperty
	a_pull: assert property (p_pull) else $error("pull-up not from detach");
	property p_addr;
		i_wr_stb && i_addr == OFS_FUNCTION_ADDR ##1 !i_wr_stb && !i_bus_reset
			|-> ##1 o_dev_addr == ($past(i_wr_data[7], 2) ? $past(i_wr_data[6:0], 2) : 7'h00);
	endproperty
	a_addr: assert property (p_addr) else $error("address in use wrong");
	property p_brst; i_bus_reset && !i_wr_stb ##1 !i_wr_stb |-> ##1 o_dev_addr == 7'h00; endproperty
	a_brst: assert property (p_brst) else $error("bus reset kept address");
	property p_hs; i_tok_valid |=> o_hs_valid; endproperty
	a_hs: assert property (p_hs) else $error("no handshake after token");
	property p_quiet; !i_tok_valid |=> !o_hs_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("handshake without token");
	property p_wake; o_drive_resume |-> o_link_power_state == 7'h20; endproperty
	a_wake: assert property (p_wake) else $error("resume drive outside state");
	c_brst: cover property (i_bus_reset ##1 o_link_power_state == 7'h40);
	c_wake: cover property (o_drive_resume);
	c_tok: cover property (i_tok_valid ##1 o_hs_valid);
endmodule : udc_ctrl_regs_chk
bind udc_ctrl_regs udc_ctrl_regs_chk #(.RESUME_CYCLES(RESUME_CYCLES)) u_chk (.i_clk_sys, .i_srst,
	.i_addr, .i_wr_data, .i_wr_stb, .i_ctrl_enable, .i_bus_reset, .i_tok_valid, .o_hs_valid,
	.o_pullup_en, .o_drive_resume, .o_dev_addr, .o_link_power_state);
`default_nettype wire

//--- bench/udc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module udc_host_model (
	input  wire logic        i_clk_sys,
	output logic             o_tok_valid,
	output logic             o_tok_ep0,
	output logic             o_tok_setup,
	output logic             o_tok_lpm,
	output udc_pkg::udc_hs_t o_ep_status,
	output logic             o_bus_reset,
	output logic [1:0]       o_line_state
);
	import udc_pkg::*;
	initial begin
		{o_tok_valid, o_tok_ep0, o_tok_setup, o_tok_lpm, o_bus_reset} = 5'h00;
		o_ep_status = HS_NONE;
		o_line_state = 2'h1;
	end
	task automatic lines(input logic r, input logic [1:0] ls);
		@(posedge i_clk_sys);
		o_bus_reset <= r;
		o_line_state <= ls;
	endtask : lines
	// Status is scrambled after the token so a stale value cannot pass
	task automatic tok(input logic [2:0] k, input udc_hs_t s);
		@(posedge i_clk_sys);
		o_tok_valid <= 1'b1;
		{o_tok_ep0, o_tok_setup, o_tok_lpm} <= k;
		o_ep_status <= s;
		@(posedge i_clk_sys);
		o_tok_valid <= 1'b0;
		o_ep_status <= udc_hs_t'(~s);
	endtask : tok
endmodule : udc_host_model
`default_nettype wire

//--- bench/test_usb_device_control_registers.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module test_usb_device_control_registers;
	import udc_pkg::*;
	logic        i_clk_sys = 1'b0, i_srst = 1'b1, i_wr_stb = 1'b0, i_rd_stb = 1'b0;
	logic        i_ctrl_enable = 1'b0, o_hs_valid, o_pullup_en;
	logic [3:0]  ev = 4'h0;
	logic        i_tok_valid, i_tok_ep0, i_tok_setup, i_tok_lpm, i_bus_reset;
	logic        o_speed_low, o_drive_resume;
	logic [1:0]  i_line_state;
	logic [2:0]  o_edge_trim;
	logic [4:0]  o_nmos_trim, o_pmos_trim;
	logic [6:0]  o_dev_addr, o_link_power_state;
	logic [7:0]  i_addr = 8'h00;
	logic [31:0] i_wr_data = 32'h0, o_rd_data, o_desc_base, lfsr = 32'h0881, d;
	udc_hs_t     i_ep_status, o_hs_code, st;
	int          failures = 0, comparisons = 0, i;
	udc_ctrl_regs #(.RESUME_CYCLES(8)) dut (.i_clk_sys, .i_srst, .i_addr, .i_wr_data, .i_wr_stb,
		.i_rd_stb, .o_rd_data, .i_ctrl_enable, .i_bus_reset, .i_suspend_det(ev[0]),
		.i_lpm_sleep(ev[1]), .i_resume_det(ev[2]), .i_resume_end(ev[3]), .i_line_state,
		.i_tok_valid, .i_tok_ep0,
		.i_tok_setup, .i_tok_lpm, .i_ep_status, .o_hs_valid, .o_hs_code, .o_pullup_en,
		.o_speed_low, .o_drive_resume, .o_dev_addr, .o_desc_base, .o_edge_trim, .o_nmos_trim,
		.o_pmos_trim, .o_link_power_state);
	udc_host_model host (.i_clk_sys, .o_tok_valid(i_tok_valid), .o_tok_ep0(i_tok_ep0),
		.o_tok_setup(i_tok_setup), .o_tok_lpm(i_tok_lpm), .o_ep_status(i_ep_status),
		.o_bus_reset(i_bus_reset), .o_line_state(i_line_state));
	always #2 i_clk_sys = ~i_clk_sys;
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	function automatic udc_hs_t lpm_ans(input logic [1:0] v);
		return v == LPM_ACK ? HS_ACK : v == LPM_NYET ? HS_NYET : HS_NONE;
	endfunction : lpm_ans
	function automatic logic [12:0] trims(input logic [31:0] v);
		return {v[14:12], v[10:6], v[4:0]};
	endfunction : trims
	task automatic summarize;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wr_data <= v;
		i_wr_stb <= 1'b1;
		@(posedge i_clk_sys);
		i_wr_stb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd_stb <= 1'b1;
		@(posedge i_clk_sys);
		i_rd_stb <= 1'b0;
		#1 `CHK(o_rd_data, e)
	endtask : rd
	task automatic tk(input logic [2:0] k, input udc_hs_t s, input udc_hs_t e);
		host.tok(k, s);
		#1 `CHK({o_hs_valid, o_hs_code}, {1'b1, e})
	endtask : tk
	// Bounded poll; a state that never comes ends the run
	task automatic wp(input logic [6:0] e);
		int n;
		#1;
		for (n = 0; n < 40 && o_link_power_state !== e; n++)
			@(posedge i_clk_sys) #1;
		`CHK(o_link_power_state, e)
		if (o_link_power_state !== e)
			summarize();
	endtask : wp
	// Link events: suspend, sleep, host resume, resume end
	task automatic go(input logic [3:0] v, input logic [6:0] e);
		@(posedge i_clk_sys);
		ev <= v;
		wp(e);
	endtask : go
	initial begin
		repeat (12) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		rd(8'h08, 32'h1);
		rd(8'h0C, 32'h44);
		rd(8'h0D, 32'h1);
		rd(8'h30, 32'h0);
		for (i = 0; i < 8; i++) begin
			lfsr = nxt(lfsr);
			d = {lfsr[31:2], 2'h0};
			wr(8'h24, d);
			wr(8'h28, {16'h0, lfsr[15:0] & MASK_PAD_TRIM});
			rd(8'h24, d);
			`CHK(o_desc_base, d)
			rd(8'h28, {16'h0, lfsr[15:0] & MASK_PAD_TRIM});
			`CHK({o_edge_trim, o_nmos_trim, o_pmos_trim}, trims(lfsr))
		end
		@(posedge i_clk_sys);
		i_ctrl_enable <= 1'b1;
		wr(8'h08, 32'h0);
		wp(7'h02);
		`CHK(o_pullup_en, 1'b1)
		for (i = 0; i < 4; i++) begin
			wr(8'h08, {20'h0, i[1:0], 10'h0});
			tk(3'h1, HS_STALL, lpm_ans(i[1:0]));
		end
		for (i = 0; i < 8; i++) begin
			lfsr = nxt(lfsr);
			st = udc_hs_t'({1'b0, lfsr[2:1]});
			wr(8'h08, {22'h0, lfsr[3], 9'h0});
			tk({lfsr[0], 2'h0}, st, lfsr[3] ? HS_NAK : st);
		end
		wr(8'h08, 32'h10);
		tk(3'h4, HS_ACK, HS_NONE);
		tk(3'h0, HS_ACK, HS_ACK);
		tk(3'h6, HS_ACK, HS_ACK);
		rd(8'h08, 32'h0);
		wr(8'h08, 32'h4);
		host.lines(1'b0, 2'h2);
		rd(8'h0C, 32'h80);
		`CHK(o_speed_low, 1'b1)
		wr(8'h0A, {24'h0, 1'b1, lfsr[6:0]});
		rd(8'h0A, {24'h0, 1'b1, lfsr[6:0]});
		`CHK(o_dev_addr, lfsr[6:0])
		host.lines(1'b1, 2'h0);
		wp(7'h40);
		host.lines(1'b0, 2'h1);
		wp(7'h02);
		rd(8'h0A, 32'h0);
		go(4'h2, 7'h08);
		go(4'h4, 7'h10);
		go(4'h8, 7'h02);
		go(4'h1, 7'h04);
		go(4'h0, 7'h04);
		wr(8'h08, 32'h2);
		wp(7'h20);
		`CHK(o_drive_resume, 1'b1)
		wr(8'h08, 32'h0);
		rd(8'h08, 32'h2);
		wp(7'h02);
		rd(8'h08, 32'h0);
		wr(8'h08, 32'hD);
		wp(7'h01);
		`CHK(o_pullup_en, 1'b0)
		`CHK(o_speed_low, 1'b0)
		rd(8'h0C, 32'h44);
		summarize();
	end
endmodule : test_usb_device_control_registers
`default_nettype wire
